//--- verilog/read_in_pkg.sv
// Constants shared by the read-in sequencer and its ratio divider.
// Assumes one clock (the store clock, aclk) and an AXI4-Lite register port.
package read_in_pkg;
  // Store geometry
  localparam int MAIN_MOD = 513;
  localparam logic [9:0] MAIN_LAST = 10'h200;
  localparam logic [9:0] PRESET_POINT = 10'h040;
  localparam logic [9:0] HOLD_PRESET = 10'h002;
  localparam logic [8:0] WRITE_LAST = 9'h1ff;
  // Write request stretch, strictly between 64 and 128 store clocks
  localparam int STRETCH_MIN = 64;
  localparam int STRETCH_MAX = 128;
  localparam logic [6:0] STRETCH_CYC = 7'(STRETCH_MIN + (STRETCH_MAX - STRETCH_MIN) / 2);
  // Ratio select field layout
  localparam int MANT_LSB = 0;
  localparam int DEC_LSB = 2;
  localparam logic [1:0] MANT_ONE = 2'h0;
  localparam logic [1:0] MANT_TWO = 2'h1;
  localparam logic [1:0] MANT_FIVE = 2'h2;
  localparam int DEC_STAGES = 2;
  // Register map (byte addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Status bit positions
  localparam int ST_HOLD = 0;
  localparam int ST_START = 1;
  localparam int ST_WREQ = 2;
  localparam int ST_DWELL = 3;
  localparam int ST_SPEED_LSB = 4;
  localparam int ST_WCOUNT_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : read_in_pkg

//--- verilog/ratio_if.sv
// Link between the sequencer and its 1-2-5 ratio divider.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ratio_if;
  logic tick;
  logic halt;
  logic clear;
  logic [3:0] ratio_sel;
  logic out_pulse;
  modport src (output tick, output halt, output clear, output ratio_sel, input out_pulse);
  modport div (input tick, input halt, input clear, input ratio_sel, output out_pulse);
endinterface : ratio_if
`default_nettype wire

//--- verilog/ratio_divider.sv
// Programmable 1-2-5 divider: /1, /2 or /5 mantissa stage then decade stages.
// Assumes tick is a one-cycle pulse and ratio_sel is already latched.
`timescale 1ns/1ps
`default_nettype none
module ratio_divider
  import read_in_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sequencer side
  ratio_if.div dv
);
  logic [1:0] mant;
  logic [1:0] dec;
  logic [2:0] m_q;
  logic m_pulse;
  logic [DEC_STAGES:0] chain;
  logic [3:0] d_q [DEC_STAGES];

  assign mant = dv.ratio_sel[MANT_LSB +: 2];
  assign dec = dv.ratio_sel[DEC_LSB +: 2];

  // R22 dwell freezes the divider
  always_ff @(posedge aclk) begin
    if (!aresetn || dv.clear) begin
      m_q <= 3'h0;
    end else if (dv.tick && !dv.halt) begin
      if ((mant == MANT_TWO && m_q == 3'h1) || (mant == MANT_FIVE && m_q == 3'h4)) begin
        m_q <= 3'h0;
      end else begin
        m_q <= m_q + 3'h1;
      end
    end
  end

  // R02 mantissa stage picks /1, /2 or /5
  always_comb begin
    case (mant)
      MANT_TWO: m_pulse = dv.tick && !dv.halt && m_q == 3'h1;
      MANT_FIVE: m_pulse = dv.tick && !dv.halt && m_q == 3'h4;
      default: m_pulse = dv.tick && !dv.halt;
    endcase
  end

  assign chain[0] = m_pulse;

  // R02 decade stages gated in by the latched command
  genvar i;
  generate
    for (i = 0; i < DEC_STAGES; i++) begin : g_dec
      logic used;
      assign used = (dec > 2'(i));
      always_ff @(posedge aclk) begin
        if (!aresetn || dv.clear || !used) begin
          d_q[i] <= 4'h0;
        end else if (chain[i]) begin
          d_q[i] <= (d_q[i] == 4'h9) ? 4'h0 : d_q[i] + 4'h1;
        end
      end
      assign chain[i+1] = used ? (chain[i] && d_q[i] == 4'h9) : chain[i];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn || dv.clear) begin
      dv.out_pulse <= 1'b0;
    end else begin
      dv.out_pulse <= chain[DEC_STAGES];
    end
  end
endmodule : ratio_divider
`default_nettype wire

//--- verilog/read_in_seq.sv
// Read-in sequence controller: decides when sampled data enters the
// recirculating store. aclk is the store clock; registers over AXI4-Lite.
// Assumes end_of_store, dwell and meas_active are synchronous to aclk.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01 - Main counter wraps every 513 clocks
// R02 - Cycle output drives 1-2-5 ratio divider
// R03 - Only latched speed command selects stages
// R04 - Write request stretched 64 to 128 clocks
// R05 - Request at count 64 gives preset pulse
// R06 - Request ends before next count 64
// R07 - Each write shifts write point 64
// R08 - Preset pulses gated by store selection
// R09 - Ungated preset pulses step scan ramp
// R10 - Write counter limits sweep to 512
// R11 - Write counter wrap requests centre measurement
// R12 - Sweep complete sets hold, low preset two
// R13 - Start reset never fires sweep complete
// R14 - Write counter low bit picks store
// R15 - End-of-store blocked during measurement period
// R16 - Auto mode end-of-store clears hold
// R17 - Single mode needs start before clearing
// R18 - Start press outside manual sets hold
// R19 - Hold falling edge resets start latch
// R20 - Manual holds counters, start ignored
// R21 - Manual edge gives substitute measurement reply
// R22 - Dwell halts divider, main counter runs
// R23 - Buttons synchronised, single-cycle edge detection (start_button used as a level; only manual_mode edge-detected)
module read_in_seq
  import read_in_pkg::*;
#(
  // Index of the last write request of a sweep
  parameter logic [8:0] LAST_WRITE = WRITE_LAST
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [3:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Store and front panel
  input wire logic end_of_store,
  input wire logic start_button,
  input wire logic manual_mode,
  input wire logic auto_mode,
  input wire logic refresh_sel,
  // Scan generator and frequency counter
  input wire logic dwell,
  input wire logic meas_active,
  output logic store_write,
  output logic ordinate_step,
  output logic sweep_complete,
  output logic manual_t_reply,
  output logic store_a_sel,
  output logic store_b_sel
);
  ratio_if rif ();

  logic [9:0] main_q;
  logic main_wrap;
  logic [3:0] speed_cmd_q;
  logic [3:0] speed_latch_q;
  logic [6:0] stretch_q;
  logic wr_req_q;
  logic preset_q;
  logic [8:0] wcount_q;
  logic sweep_hold_q;
  logic hold_prev_q;
  logic start_latch_q;
  logic [2:0] start_s_q;
  logic [2:0] manual_s_q;
  logic [1:0] auto_s_q;
  logic start_now;
  logic manual_now;
  logic eos_clear;
  logic sweep_done;
  logic aw_have_q;
  logic w_have_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // R23 two-flop synchronisers, edges read past stage one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_s_q <= 3'h0;
      manual_s_q <= 3'h0;
      auto_s_q <= 2'h0;
    end else begin
      start_s_q <= {start_s_q[1:0], start_button};
      manual_s_q <= {manual_s_q[1:0], manual_mode};
      auto_s_q <= {auto_s_q[0], auto_mode};
    end
  end

  assign start_now = start_s_q[1];
  assign manual_now = manual_s_q[1];

  // R01 modulo-513 main counter
  // R05 preset pulse loads zero next clock
  // R12 hold presets low stage to two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_q <= 10'h0;
    end else if (sweep_hold_q) begin
      main_q <= HOLD_PRESET;
    end else if (preset_q) begin
      main_q <= 10'h0;
    end else if (main_q == MAIN_LAST) begin
      main_q <= 10'h0;
    end else begin
      main_q <= main_q + 10'h1;
    end
  end

  assign main_wrap = !sweep_hold_q && !preset_q && main_q == MAIN_LAST;

  // R03 speed latch follows command only between sweeps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_latch_q <= CTRL_RESET;
    end else if (sweep_hold_q) begin
      speed_latch_q <= speed_cmd_q;
    end
  end

  // R02 main cycle feeds ratio divider
  // R22 dwell halts only the divider
  assign rif.tick = main_wrap;
  assign rif.halt = dwell;
  assign rif.clear = sweep_hold_q;
  assign rif.ratio_sel = speed_latch_q;

  ratio_divider ratio_divider_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .dv(rif.div)
  );

  // R04 stretch each divider output
  // R06 stretch ends before restart reaches 64
  always_ff @(posedge aclk) begin
    if (!aresetn || sweep_hold_q) begin
      stretch_q <= 7'h0;
      wr_req_q <= 1'b0;
    end else if (rif.out_pulse) begin
      stretch_q <= STRETCH_CYC - 7'h1;
      wr_req_q <= 1'b1;
    end else if (stretch_q != 7'h0) begin
      stretch_q <= stretch_q - 7'h1;
    end else begin
      wr_req_q <= 1'b0;
    end
  end

  // R05 one-clock preset enable at count 64
  // R07 restart from zero moves write point 64
  always_ff @(posedge aclk) begin
    if (!aresetn || sweep_hold_q) begin
      preset_q <= 1'b0;
    end else begin
      preset_q <= wr_req_q && !preset_q && main_q == PRESET_POINT;
    end
  end

  // R08 store selection gates auto write strobe
  // R09 ungated pulses step the scan ramp
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_write <= 1'b0;
      ordinate_step <= 1'b0;
    end else begin
      store_write <= preset_q && refresh_sel;
      ordinate_step <= preset_q;
    end
  end

  // R10 write counter modulo 512
  always_ff @(posedge aclk) begin
    if (!aresetn || sweep_hold_q) begin
      wcount_q <= 9'h0;
    end else if (rif.out_pulse) begin
      wcount_q <= wcount_q + 9'h1;
    end
  end

  // R11 wrap of write counter ends sweep
  // R13 counter reset or start press never fires it
  assign sweep_done = rif.out_pulse && wcount_q == LAST_WRITE && !sweep_hold_q && !start_now;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sweep_complete <= 1'b0;
    end else begin
      sweep_complete <= sweep_done;
    end
  end

  // R14 low write count bit picks store A or B
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_a_sel <= 1'b1;
      store_b_sel <= 1'b0;
    end else begin
      store_a_sel <= !wcount_q[0];
      store_b_sel <= wcount_q[0];
    end
  end

  // R15 no clearing during measurement period
  // R16 auto mode passes end-of-store
  // R17 single mode waits for start latch
  // R20 manual keeps the hold set
  assign eos_clear = end_of_store && !meas_active && !start_now && !manual_now
    && (auto_s_q[1] || start_latch_q);

  // R12 sweep complete sets hold
  // R18 start press outside manual sets hold
  // R20 manual holds counters reset
  // Set terms win over an end-of-store clear in the same clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sweep_hold_q <= 1'b1;
    end else if (sweep_done || manual_now || start_now) begin
      sweep_hold_q <= 1'b1;
    end else if (eos_clear) begin
      sweep_hold_q <= 1'b0;
    end
  end

  // R19 start latch cleared on hold falling edge
  // R20 start ignored in manual mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_prev_q <= 1'b1;
      start_latch_q <= 1'b0;
    end else begin
      hold_prev_q <= sweep_hold_q;
      if (start_now && !manual_now) begin
        start_latch_q <= 1'b1;
      end else if (hold_prev_q && !sweep_hold_q) begin
        start_latch_q <= 1'b0;
      end
    end
  end

  // R21 manual press imitates measurement reply
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      manual_t_reply <= 1'b0;
    end else begin
      manual_t_reply <= manual_s_q[1] && !manual_s_q[2];
    end
  end

  // Write path: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axil_awready <= 1'b1;
      s_axil_wready <= 1'b1;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= RESP_OKAY;
      speed_cmd_q <= CTRL_RESET;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axil_awaddr;
        s_axil_awready <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axil_wdata;
        w_strb_q <= s_axil_wstrb;
        s_axil_wready <= 1'b0;
      end
      if (aw_have_q && w_have_q && !s_axil_bvalid) begin
        s_axil_bvalid <= 1'b1;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        if (aw_addr_q == ADDR_CTRL) begin
          s_axil_bresp <= RESP_OKAY;
          if (w_strb_q[0]) begin
            speed_cmd_q <= w_data_q[3:0];
          end
        end else if (aw_addr_q == ADDR_STATUS || aw_addr_q == ADDR_COUNT) begin
          s_axil_bresp <= RESP_OKAY;
        end else begin
          s_axil_bresp <= RESP_SLVERR;
        end
      end
      if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
        s_axil_awready <= 1'b1;
        s_axil_wready <= 1'b1;
      end
    end
  end

  // Read path; unmapped addresses read zero with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0;
      s_axil_rresp <= RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b1;
      s_axil_rresp <= RESP_OKAY;
      s_axil_rdata <= 32'h0;
      case (s_axil_araddr)
        ADDR_CTRL: s_axil_rdata <= {28'h0, speed_cmd_q};
        ADDR_STATUS: begin
          s_axil_rdata[ST_HOLD] <= sweep_hold_q;
          s_axil_rdata[ST_START] <= start_latch_q;
          s_axil_rdata[ST_WREQ] <= wr_req_q;
          s_axil_rdata[ST_DWELL] <= dwell;
          s_axil_rdata[ST_SPEED_LSB +: 4] <= speed_latch_q;
          s_axil_rdata[ST_WCOUNT_LSB +: 9] <= wcount_q;
        end
        ADDR_COUNT: s_axil_rdata <= {22'h0, main_q};
        default: s_axil_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axil_rvalid && s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
      s_axil_arready <= 1'b1;
    end
  end
endmodule : read_in_seq
`default_nettype wire

//--- sim/store_partner.sv
// Far side model: store end pulses, frequency counter timing.
// Assumes the sequencer runs on the same store clock.
`timescale 1ns/1ps
`default_nettype none
module store_partner #(
  parameter int MEAS_CYC = 1200,
  parameter int DWELL_CYC = 1500
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench controls
  input wire logic eos_run,
  input wire logic meas_kick,
  // Sequencer side
  input wire logic sweep_complete,
  output logic end_of_store,
  output logic meas_active,
  output logic dwell
);
  logic [9:0] pos_q;
  int tmr_q;
  // Store recirculates 513 positions
  always_ff @(posedge aclk) begin
    if (!aresetn || !eos_run) begin
      pos_q <= 10'h000;
      end_of_store <= 1'h0;
    end else begin
      pos_q <= (pos_q == 10'h200) ? 10'h000 : pos_q + 10'h001;
      end_of_store <= (pos_q == 10'h200);
    end
  end
  // Measurement period, then settling dwell
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_q <= 0;
    end else if (sweep_complete || meas_kick) begin
      tmr_q <= MEAS_CYC + DWELL_CYC;
    end else if (tmr_q != 0) begin
      tmr_q <= tmr_q - 1;
    end
  end
  assign meas_active = tmr_q > DWELL_CYC;
  assign dwell = (tmr_q != 0) && !meas_active;
endmodule : store_partner
`default_nettype wire

//--- sim/read_in_seq_sva.sv
// Checker on the read-in sequencer top ports.
// Assumes a single store clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module read_in_seq_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // Sequencer
  input wire logic manual_mode,
  input wire logic store_write,
  input wire logic ordinate_step,
  input wire logic sweep_complete,
  input wire logic manual_t_reply,
  input wire logic store_a_sel,
  input wire logic store_b_sel
);
  logic [10:0] gap_q;
  logic seen_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since last step, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= 11'h000;
      seen_q <= 1'h0;
    end else if (ordinate_step) begin
      gap_q <= 11'h001;
      seen_q <= 1'h1;
    end else if (gap_q != 11'h7ff) begin
      gap_q <= gap_q + 11'h001;
    end
  end
  a_write_gated: assert property (store_write |-> ordinate_step)
    else $error("store write without step");
  a_step_single: assert property (ordinate_step |=> !ordinate_step)
    else $error("step longer than one cycle");
  a_step_spacing: assert property (ordinate_step && seen_q |-> gap_q >= 11'h201)
    else $error("two steps within one store cycle");
  a_store_excl: assert property (store_a_sel != store_b_sel)
    else $error("store selects not complementary");
  a_manual_reply: assert property ($rose(manual_mode) |-> ##[2:4] manual_t_reply)
    else $error("no reply after manual edge");
  a_reply_single: assert property (manual_t_reply |=> !manual_t_reply [*4])
    else $error("reply not a single pulse");
  a_manual_quiet: assert property (manual_mode [*8] |-> !ordinate_step)
    else $error("step while manual");
  a_done_pulse: assert property (sweep_complete |=> !sweep_complete)
    else $error("sweep complete too long");
  a_read_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read not answered");
  a_bvalid_hold: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
    else $error("write response dropped");
  c_store: cover property (store_write);
  c_gap: cover property (ordinate_step && seen_q);
  c_reply: cover property (manual_t_reply);
  c_done: cover property (sweep_complete);
endmodule : read_in_seq_sva
bind read_in_seq read_in_seq_sva read_in_seq_sva_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
  .s_axil_rvalid(s_axil_rvalid), .s_axil_bvalid(s_axil_bvalid),
  .s_axil_bready(s_axil_bready), .manual_mode(manual_mode), .store_write(store_write),
  .ordinate_step(ordinate_step), .sweep_complete(sweep_complete),
  .manual_t_reply(manual_t_reply), .store_a_sel(store_a_sel), .store_b_sel(store_b_sel));
`default_nettype wire

//--- sim/read_in_seq_tb.sv
// Self-checking bench for the read-in sequencer with far side model.
// Assumes a 40 MHz store clock; registers reached over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  $display("ERROR %s expected %h seen %h", n, e, g); fail_count++; end end
module read_in_seq_tb;
  import read_in_pkg::*;
  // Short sweep keeps a full sweep inside the run
  localparam logic [8:0] SWEEP_LAST = 9'h00f;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d, c1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, b0;
  logic [1:0] bresp, rresp, r;
  logic start_button = 1'h0, manual_mode = 1'h0, auto_mode = 1'h0, refresh_sel = 1'h1;
  logic eos_run = 1'h0, meas_kick = 1'h0;
  logic end_of_store, dwell, meas_active, store_write, ordinate_step;
  logic sweep_complete, manual_t_reply, store_a_sel, store_b_sel;
  int fail_count = 0, check_count = 0, n_step = 0, n_sw = 0, n_rep = 0, n_done = 0;
  int cyc = 0, last_t = 0, gap = 0, s0;
  initial forever #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (ordinate_step === 1'h1) begin
      n_step++;
      gap = cyc - last_t;
      last_t = cyc;
    end
    if (store_write === 1'h1) n_sw++;
    if (manual_t_reply === 1'h1) n_rep++;
    if (sweep_complete === 1'h1) n_done++;
  end
  read_in_seq #(.LAST_WRITE(SWEEP_LAST)) read_in_seq_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr),
    .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
    .s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
    .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(rready), .end_of_store(end_of_store), .start_button(start_button),
    .manual_mode(manual_mode), .auto_mode(auto_mode), .refresh_sel(refresh_sel),
    .dwell(dwell), .meas_active(meas_active), .store_write(store_write),
    .ordinate_step(ordinate_step), .sweep_complete(sweep_complete),
    .manual_t_reply(manual_t_reply), .store_a_sel(store_a_sel), .store_b_sel(store_b_sel));
  store_partner store_partner_inst (.aclk(aclk), .aresetn(aresetn), .eos_run(eos_run),
    .meas_kick(meas_kick), .sweep_complete(sweep_complete), .end_of_store(end_of_store),
    .meas_active(meas_active), .dwell(dwell));
  task summarize;
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        bready <= 1'h0;
        `CHK("bresp", er, bresp)
        return;
      end
    end
    `CHK("write done", 1'h1, 1'h0)
    summarize();
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        rready <= 1'h0;
        d = rdata;
        r = rresp;
        return;
      end
    end
    `CHK("read done", 1'h1, 1'h0)
    summarize();
  endtask : rd
  task automatic hold_wait(input logic e);
    for (int i = 0; i < 80; i++) begin
      rd(ADDR_STATUS);
      if (d[ST_HOLD] === e) break;
      repeat (16) @(posedge aclk);
    end
    `CHK("hold", e, d[ST_HOLD])
  endtask : hold_wait
  task automatic steps(input int n);
    int t;
    t = n_step + n;
    for (int i = 0; i < 12000 && n_step < t; i++) @(posedge aclk);
    `CHK("step seen", 1'h1, n_step >= t)
  endtask : steps
  task t_regs;
    rd(ADDR_CTRL);
    `CHK("ctrl reset", 32'h0, d)
    wr(ADDR_CTRL, 32'h5, RESP_OKAY);
    rd(ADDR_STATUS);
    `CHK("latched speed", 4'h5, d[ST_SPEED_LSB +: 4])
    wr(4'hc, 32'h1, RESP_SLVERR);
    rd(4'hc);
    `CHK("unmapped", {RESP_SLVERR, 32'h0}, {r, d})
    wr(ADDR_STATUS, 32'hff, RESP_OKAY);
  endtask : t_regs
  task t_single;
    eos_run <= 1'h1;
    repeat (1100) @(posedge aclk);
    rd(ADDR_STATUS);
    `CHK("single held", 1'h1, d[ST_HOLD])
    start_button <= 1'h1;
    repeat (20) @(posedge aclk);
    start_button <= 1'h0;
    hold_wait(1'h0);
    rd(ADDR_STATUS);
    `CHK("start latch", 1'h0, d[ST_START])
    auto_mode <= 1'h1;
  endtask : t_single
  task automatic t_ratio;
    logic [3:0] sel [4] = '{4'h4, 4'h2, 4'h1, 4'h0};
    int dv [4] = '{10, 5, 2, 1};
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      start_button <= 1'h1;
      wr(ADDR_CTRL, {28'h0, sel[k]}, RESP_OKAY);
      rd(ADDR_STATUS);
      `CHK("start hold", 1'h1, d[ST_HOLD])
      start_button <= 1'h0;
      hold_wait(1'h0);
      steps(2);
      `CHK("ratio", dv[k], gap / MAIN_MOD)
      `CHK("shift", 1'h1, gap % MAIN_MOD >= 64 && gap % MAIN_MOD <= 66)
      wr(ADDR_CTRL, 32'h3, RESP_OKAY);
      rd(ADDR_STATUS);
      `CHK("speed frozen", sel[k], d[ST_SPEED_LSB +: 4])
    end
  endtask : t_ratio
  task t_store;
    s0 = n_sw - n_step;
    b0 = store_b_sel;
    steps(1);
    `CHK("store b", ~b0, store_b_sel)
    `CHK("store a", b0, store_a_sel)
    `CHK("writes", s0, n_sw - n_step)
    refresh_sel <= 1'h0;
    steps(1);
    refresh_sel <= 1'h1;
    `CHK("gated", s0 - 1, n_sw - n_step)
  endtask : t_store
  task t_dwell;
    meas_kick <= 1'h1;
    @(posedge aclk);
    meas_kick <= 1'h0;
    repeat (1250) @(posedge aclk);
    s0 = n_step;
    rd(ADDR_COUNT);
    c1 = d;
    repeat (1300) @(posedge aclk);
    rd(ADDR_COUNT);
    `CHK("main runs", 1'h1, c1 !== d)
    `CHK("divider halt", 1'h1, n_step - s0 <= 1)
    steps(1);
  endtask : t_dwell
  task t_meas;
    start_button <= 1'h1;
    repeat (20) @(posedge aclk);
    start_button <= 1'h0;
    meas_kick <= 1'h1;
    @(posedge aclk);
    meas_kick <= 1'h0;
    repeat (1150) @(posedge aclk);
    rd(ADDR_STATUS);
    `CHK("eos blocked", 1'h1, d[ST_HOLD])
    hold_wait(1'h0);
  endtask : t_meas
  task automatic t_sweep;
    int s1, n1;
    s1 = n_step;
    n1 = n_done;
    for (int i = 0; i < 20000 && n_done == n1; i++) @(posedge aclk);
    `CHK("sweep done", n1 + 1, n_done)
    `CHK("writes per sweep", int'(SWEEP_LAST), n_step - s1)
    rd(ADDR_COUNT);
    `CHK("low preset", {22'h0, HOLD_PRESET}, d)
    repeat (1000) @(posedge aclk);
    rd(ADDR_STATUS);
    `CHK("hold in meas", 1'h1, d[ST_HOLD])
    hold_wait(1'h0);
  endtask : t_sweep
  task t_manual;
    s0 = n_rep;
    manual_mode <= 1'h1;
    repeat (12) @(posedge aclk);
    `CHK("replies", s0 + 1, n_rep)
    rd(ADDR_STATUS);
    `CHK("manual hold", 1'h1, d[ST_HOLD])
    s0 = n_step;
    // Start kept idle in manual, as the interlock does
    repeat (1200) @(posedge aclk);
    `CHK("no steps", s0, n_step)
    manual_mode <= 1'h0;
    hold_wait(1'h0);
  endtask : t_manual
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_single();
    t_ratio();
    t_store();
    t_dwell();
    t_meas();
    t_sweep();
    t_manual();
    summarize();
  end
endmodule : read_in_seq_tb
`default_nettype wire
